//--- core/fic_cap_word.sv
// Capability word: strap synchroniser, one-time capture and field assembly
`timescale 1ns/10ps
`default_nettype none
module fic_cap_word
  import fic_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Strap pins
  input  wire logic [FIC_STRAP_W-1:0] strap_in,
  // Captured capability
  output var  logic [31:0]            cap_word,
  output var  logic                   lpc_mode
);

  logic [FIC_STRAP_W-1:0] sync1_r, sync2_r, held_r, held_nxt;
  logic [1:0]             fill_r, fill_nxt;
  logic                   done_r, done_nxt;

  // Straps are sampled once; later pin wiggles cannot change the word
  always_comb begin
    fill_nxt = fill_r;
    done_nxt = done_r;
    held_nxt = held_r;
    if (!done_r) begin
      if (fill_r == FIC_SYNC_FILL) begin
        held_nxt = sync2_r;
        done_nxt = 1'b1;
      end else begin
        fill_nxt = fill_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    sync1_r <= strap_in;
    sync2_r <= sync1_r;
    if (!rst_n) begin
      fill_r <= 2'h0;
      done_r <= 1'b0;
      held_r <= '0;
    end else begin
      fill_r <= fill_nxt;
      done_r <= done_nxt;
      held_r <= held_nxt;
    end
  end

  always_comb begin
    cap_word                              = FIC_CAP_RESET;
    cap_word[FIC_BIT_TOP_RSVD]            = held_r[11];
    cap_word[FIC_REV_HI:FIC_REV_LO]       = held_r[10:8];
    cap_word[FIC_ZERO_HI:FIC_ZERO_LO]     = '0;
    cap_word[FIC_SIZE_HI:FIC_SIZE_LO]     = held_r[7:6];
    cap_word[FIC_BIT_BURST_FIXED]         = held_r[5];
    cap_word[FIC_BIT_CMD_RDY]             = held_r[4];
    cap_word[FIC_BIT_FALL]                = held_r[3];
    cap_word[FIC_BIT_RISE]                = held_r[2];
    cap_word[FIC_BIT_LOW_LVL]             = 1'b1;
    cap_word[FIC_BIT_HIGH_LVL]            = held_r[1];
    cap_word[FIC_BIT_OWNER_CHG]           = 1'b1;
    cap_word[FIC_BIT_STS_VALID]           = held_r[0];
    cap_word[FIC_BIT_RESP_RDY]            = 1'b1;
    lpc_mode                              = held_r[12];
  end

endmodule
`default_nettype wire

//--- core/fic_dec_if.sv
// Interface: request decode between the top and the acceptance gate
`timescale 1ns/10ps
`default_nettype none
interface fic_dec_if;
  import fic_pkg::*;
  logic [15:0]  addr;
  logic [6:0]   len;
  logic [1:0]   size_limit;
  logic         lpc_mode;
  fic_verdict_t verdict;

  modport top  (output addr, len, size_limit, lpc_mode, input verdict);
  modport gate (input addr, len, size_limit, lpc_mode, output verdict);
endinterface
`default_nettype wire

//--- core/fic_gate.sv
// Acceptance gate: decides which port a request hits and whether it is taken
`timescale 1ns/10ps
`default_nettype none
module fic_gate
  import fic_pkg::*;
(
  // Decode carrier
  fic_dec_if.gate dec
);

  logic [6:0] max_len;
  logic       len_ok;

  always_comb begin
    max_len = fic_max_len(dec.size_limit);
    // Longer bursts than advertised are let through on LPC only
    len_ok  = (dec.len != 7'h00) &&
              ((dec.len <= max_len) || dec.lpc_mode);
    if (dec.addr == FIC_OFS_CAP) begin
      dec.verdict = FIC_V_CAP;
    end else if (dec.addr == FIC_OFS_BYTE_FIFO) begin
      dec.verdict = len_ok ? FIC_V_BYTE : FIC_V_ABORT;
    end else if (dec.addr == FIC_OFS_WIDE_FIFO) begin
      if (dec.size_limit == FIC_SIZE_LEGACY) begin
        dec.verdict = FIC_V_ABORT;
      end else begin
        dec.verdict = len_ok ? FIC_V_WIDE : FIC_V_ABORT;
      end
    end else begin
      dec.verdict = FIC_V_UNMAPPED;
    end
  end

endmodule
`default_nettype wire

//--- core/fic_pkg.sv
// Package: offsets, capability layout, encodings and verdicts for the capability block
package fic_pkg;

  // Register and port offsets on the host bus
  localparam logic [15:0] FIC_OFS_CAP       = 16'h0010;
  localparam logic [15:0] FIC_OFS_BYTE_FIFO = 16'h0020;
  localparam logic [15:0] FIC_OFS_WIDE_FIFO = 16'h0040;

  // Capability field positions
  localparam int FIC_BIT_TOP_RSVD    = 31;
  localparam int FIC_REV_HI          = 30;
  localparam int FIC_REV_LO          = 28;
  localparam int FIC_ZERO_HI         = 27;
  localparam int FIC_ZERO_LO         = 11;
  localparam int FIC_SIZE_HI         = 10;
  localparam int FIC_SIZE_LO         = 9;
  localparam int FIC_BIT_BURST_FIXED = 8;
  localparam int FIC_BIT_CMD_RDY     = 7;
  localparam int FIC_BIT_FALL        = 6;
  localparam int FIC_BIT_RISE        = 5;
  localparam int FIC_BIT_LOW_LVL     = 4;
  localparam int FIC_BIT_HIGH_LVL    = 3;
  localparam int FIC_BIT_OWNER_CHG   = 2;
  localparam int FIC_BIT_STS_VALID   = 1;
  localparam int FIC_BIT_RESP_RDY    = 0;

  // Word with only the mandatory bits set
  localparam logic [31:0] FIC_CAP_RESET = 32'h0000_0015;

  // Encodings
  localparam logic [1:0] FIC_SIZE_64     = 2'h3;
  localparam logic [1:0] FIC_SIZE_32     = 2'h2;
  localparam logic [1:0] FIC_SIZE_8      = 2'h1;
  localparam logic [1:0] FIC_SIZE_LEGACY = 2'h0;
  localparam logic [2:0] FIC_REV_121     = 3'h0;
  localparam logic [2:0] FIC_REV_13      = 3'h2;
  localparam logic [2:0] FIC_REV_13_G2   = 3'h3;
  localparam logic [3:0] FIC_KIND_FIFO_A = 4'h0;
  localparam logic [3:0] FIC_KIND_FIFO_B = 4'hf;

  // Transfer lengths in bytes
  localparam int          FIC_LEN_W      = 7;
  localparam logic [6:0]  FIC_MAX_64     = 7'h40;
  localparam logic [6:0]  FIC_MAX_32     = 7'h20;
  localparam logic [6:0]  FIC_MAX_8      = 7'h08;
  localparam logic [6:0]  FIC_MAX_LEGACY = 7'h01;

  // Strap bundle: {lpc, top, rev[2:0], size[1:0], burst, cmd, fall, rise, high, sts}
  localparam int         FIC_STRAP_W    = 13;
  localparam logic [1:0] FIC_SYNC_FILL  = 2'h2;

  typedef enum logic [2:0] {
    FIC_V_CAP, FIC_V_BYTE, FIC_V_WIDE, FIC_V_ABORT, FIC_V_UNMAPPED
  } fic_verdict_t;

  function automatic logic [6:0] fic_max_len(input logic [1:0] size);
    case (size)
      FIC_SIZE_64: fic_max_len = FIC_MAX_64;
      FIC_SIZE_32: fic_max_len = FIC_MAX_32;
      FIC_SIZE_8:  fic_max_len = FIC_MAX_8;
      default:     fic_max_len = FIC_MAX_LEGACY;
    endcase
  endfunction

endpackage

//--- core/fic_top.sv
// Top: capability register and FIFO port acceptance on the host transaction port
`timescale 1ns/10ps
`default_nettype none
module fic_top
  import fic_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Host transaction port
  input  wire logic        host_req,
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  input  wire logic [6:0]  host_len,
  input  wire logic        host_wvalid,
  input  wire logic [7:0]  host_wdata,
  output var  logic        host_ack,
  output var  logic        host_abort,
  output var  logic        host_wait,
  output var  logic        host_byte_ack,
  output var  logic [31:0] host_rdata,
  // Identity
  input  wire logic [3:0]  interface_kind,
  // Strap pins
  input  wire logic        strap_top_bit,
  input  wire logic [2:0]  strap_revision,
  input  wire logic [1:0]  strap_size_limit,
  input  wire logic        strap_burst_fixed,
  input  wire logic        strap_cmd_ready_irq,
  input  wire logic        strap_falling_edge,
  input  wire logic        strap_rising_edge,
  input  wire logic        strap_high_level,
  input  wire logic        strap_status_valid_irq,
  input  wire logic        strap_lpc_mode,
  // Command FIFO side
  output var  logic        fifo_wr_valid,
  output var  logic [7:0]  fifo_wr_data,
  input  wire logic        fifo_wr_ready,
  input  wire logic        fifo_rd_valid,
  input  wire logic [7:0]  fifo_rd_data,
  output var  logic        fifo_rd_take,
  // Status
  output var  logic        cap_valid,
  output var  logic        wide_port_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // Capability word and decode

  typedef enum logic [1:0] {
    FIC_S_IDLE, FIC_S_WRITE, FIC_S_READ, FIC_S_FINISH
  } fic_state_t;

  logic [31:0] cap_word;
  logic        lpc_mode;
  logic        kind_ok;
  fic_dec_if   dec ();
  logic [FIC_STRAP_W-1:0] strap_bus;

  // Pure wiring; the capture block synchronises the whole bundle
  always_comb begin
    strap_bus[12]   = strap_lpc_mode;
    strap_bus[11]   = strap_top_bit;
    strap_bus[10:8] = strap_revision;
    strap_bus[7:6]  = strap_size_limit;
    strap_bus[5]    = strap_burst_fixed;
    strap_bus[4]    = strap_cmd_ready_irq;
    strap_bus[3]    = strap_falling_edge;
    strap_bus[2]    = strap_rising_edge;
    strap_bus[1]    = strap_high_level;
    strap_bus[0]    = strap_status_valid_irq;
  end

  fic_cap_word u_cap (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .strap_in (strap_bus),
    .cap_word (cap_word),
    .lpc_mode (lpc_mode)
  );

  fic_gate u_gate (
    .dec (dec.gate)
  );

  assign dec.addr       = host_addr;
  assign dec.len        = host_len;
  assign dec.size_limit = cap_word[FIC_SIZE_HI:FIC_SIZE_LO];
  assign dec.lpc_mode   = lpc_mode;

  // Contents mean nothing for other interface kinds
  assign kind_ok = (interface_kind == FIC_KIND_FIFO_A) ||
                   (interface_kind == FIC_KIND_FIFO_B);

  ////////////////////////////////////////////////////////////////////////////
  // Transaction state

  fic_state_t  state_r, state_nxt;
  logic [6:0]  left_r, left_nxt;
  logic        ack_r, ack_nxt;
  logic        abort_r, abort_nxt;
  logic        wait_r, wait_nxt;
  logic        back_r, back_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wv_r, wv_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic        take_r, take_nxt;
  logic        push;
  logic        pull;

  // One transaction at a time; a request is only taken from idle
  always_comb begin
    state_nxt = state_r;
    left_nxt  = left_r;
    ack_nxt   = 1'b0;
    abort_nxt = 1'b0;
    wait_nxt  = 1'b0;
    back_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    push      = 1'b0;
    pull      = 1'b0;

    case (state_r)
      FIC_S_IDLE: begin
        if (host_req) begin
          case (dec.verdict)
            FIC_V_CAP: begin
              ack_nxt = 1'b1;
              // Writes land nowhere; the ack keeps the bus error-free
              if (!host_we) begin
                rdata_nxt = kind_ok ? cap_word : 32'h0000_0000;
              end
            end
            FIC_V_BYTE, FIC_V_WIDE: begin
              left_nxt  = host_len;
              rdata_nxt = 32'h0000_0000;
              state_nxt = host_we ? FIC_S_WRITE : FIC_S_READ;
            end
            FIC_V_ABORT: begin
              abort_nxt = 1'b1;
            end
            default: begin
              ack_nxt   = 1'b1;
              rdata_nxt = 32'h0000_0000;
            end
          endcase
        end
      end

      FIC_S_WRITE: begin
        if (left_r == 7'h00) begin
          state_nxt = FIC_S_FINISH;
        end else if (host_wvalid && !back_r && (!wv_r || fifo_wr_ready)) begin
          push     = 1'b1;
          back_nxt = 1'b1;
          left_nxt = left_r - 7'h01;
        end else if (host_wvalid && !back_r) begin
          // Byte held by host while the FIFO is full
          wait_nxt = 1'b1;
        end
      end

      FIC_S_READ: begin
        if (left_r == 7'h00) begin
          state_nxt = FIC_S_FINISH;
        end else if (fifo_rd_valid && !take_r && !back_r) begin
          rdata_nxt = {24'h00_0000, fifo_rd_data};
          pull      = 1'b1;
          back_nxt  = 1'b1;
          left_nxt  = left_r - 7'h01;
        end else if (!fifo_rd_valid) begin
          wait_nxt = 1'b1;
        end
      end

      FIC_S_FINISH: begin
        // Last write byte must be in the FIFO before completion
        if (!wv_r || fifo_wr_ready) begin
          ack_nxt   = 1'b1;
          state_nxt = FIC_S_IDLE;
        end else begin
          wait_nxt = 1'b1;
        end
      end

      default: begin
        state_nxt = FIC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= FIC_S_IDLE;
      left_r  <= 7'h00;
      ack_r   <= 1'b0;
      abort_r <= 1'b0;
      wait_r  <= 1'b0;
      back_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      left_r  <= left_nxt;
      ack_r   <= ack_nxt;
      abort_r <= abort_nxt;
      wait_r  <= wait_nxt;
      back_r  <= back_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command FIFO handshakes

  always_comb begin
    wv_nxt   = wv_r;
    wd_nxt   = wd_r;
    take_nxt = pull;
    // Downstream drains a pending byte on its own handshake
    if (wv_r && fifo_wr_ready) begin
      wv_nxt = 1'b0;
    end
    // A fresh byte may replace one that drains on this same edge
    if (push) begin
      wv_nxt = 1'b1;
      wd_nxt = host_wdata;
    end
  end

  // Valid and data hold together until the FIFO side takes the byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wv_r   <= 1'b0;
      wd_r   <= 8'h00;
      take_r <= 1'b0;
    end else begin
      wv_r   <= wv_nxt;
      wd_r   <= wd_nxt;
      take_r <= take_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  logic        valid_r, valid_nxt;
  logic        wide_r, wide_nxt;

  always_comb begin
    valid_nxt = kind_ok;
    wide_nxt  = cap_word[FIC_SIZE_HI:FIC_SIZE_LO] != FIC_SIZE_LEGACY;
  end

  // One cycle of lag is traded for flags that come straight from flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      wide_r  <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      wide_r  <= wide_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign host_ack          = ack_r;
  assign host_abort        = abort_r;
  assign host_wait         = wait_r;
  assign host_byte_ack     = back_r;
  assign host_rdata        = rdata_r;
  assign fifo_wr_valid     = wv_r;
  assign fifo_wr_data      = wd_r;
  assign fifo_rd_take      = take_r;
  assign cap_valid         = valid_r;
  assign wide_port_enabled = wide_r;

endmodule
`default_nettype wire

//--- verif/fic_host_model.sv
// Host controller model: one transaction at a time on the host port
`timescale 1ns/10ps
`default_nettype none
module fic_host_model (
  // Clock
  input  wire logic        sys_clk,
  // Answers
  input  wire logic        host_ack,
  input  wire logic        host_abort,
  input  wire logic        host_byte_ack,
  // Request
  output var  logic        host_req,
  output var  logic        host_we,
  output var  logic [15:0] host_addr,
  output var  logic [6:0]  host_len,
  output var  logic        host_wvalid,
  output var  logic [7:0]  host_wdata
);
  initial begin
    host_req = 1'b0;
    host_we = 1'b0;
    host_addr = 16'h0;
    host_len = 7'h0;
    host_wvalid = 1'b0;
    host_wdata = 8'h0;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [6:0] n);
    int t;
    int b;
    t = 0;
    b = 0;
    @(negedge sys_clk);
    host_req = 1'b1;
    host_we = w;
    host_addr = a;
    host_len = n;
    host_wvalid = w;
    host_wdata = 8'($urandom);
    while (host_ack !== 1'b1 && host_abort !== 1'b1 && t < 400) begin
      @(negedge sys_clk);
      t++;
      if (host_byte_ack === 1'b1 && w) begin
        b++;
        host_wvalid = (b < int'(n));
        host_wdata = 8'($urandom);
      end
    end
    // Released lines must not keep their last value
    host_req = 1'b0;
    host_wvalid = 1'b0;
    host_wdata = ~host_wdata;
    host_addr = ~host_addr;
  endtask
endmodule
`default_nettype wire

//--- verif/fic_top_asserts.sv
// Checker: answer timing and capability fields at the top module's ports
`timescale 1ns/10ps
`default_nettype none
module fic_top_asserts
  import fic_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Host port
  input wire logic        host_req,
  input wire logic        host_we,
  input wire logic [15:0] host_addr,
  input wire logic [6:0]  host_len,
  input wire logic        host_ack,
  input wire logic        host_abort,
  input wire logic        host_wait,
  input wire logic        host_byte_ack,
  input wire logic        host_wvalid,
  input wire logic [31:0] host_rdata,
  // Identity and straps
  input wire logic [3:0]  interface_kind,
  input wire logic [2:0]  strap_revision,
  input wire logic [1:0]  strap_size_limit,
  input wire logic        strap_burst_fixed,
  input wire logic        strap_cmd_ready_irq,
  input wire logic        strap_falling_edge,
  input wire logic        strap_rising_edge,
  input wire logic        strap_high_level,
  input wire logic        strap_status_valid_irq,
  input wire logic        strap_lpc_mode,
  // FIFO side and status
  input wire logic        fifo_wr_valid,
  input wire logic [7:0]  fifo_wr_data,
  input wire logic        fifo_wr_ready,
  input wire logic        fifo_rd_valid,
  input wire logic        cap_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       req_d_r;
  logic       take;
  logic       cap_rd;
  logic [6:0] max_len;
  always_ff @(posedge sys_clk) req_d_r <= host_req;
  // Host drops req after each answer, so a rise marks the taking edge
  assign take = host_req && !req_d_r;
  assign cap_rd = take && !host_we && host_addr == FIC_OFS_CAP;
  assign max_len = strap_size_limit == FIC_SIZE_64 ? FIC_MAX_64 :
                   strap_size_limit == FIC_SIZE_32 ? FIC_MAX_32 :
                   strap_size_limit == FIC_SIZE_8 ? FIC_MAX_8 : FIC_MAX_LEGACY;
  a_cap_mandatory: assert property (
    cap_rd && cap_valid |=> host_ack && host_rdata[27:11] == 17'h0 && host_rdata[4]
      && host_rdata[2] && host_rdata[0]) else $error("capability fixed bits wrong");
  a_cap_size: assert property (
    cap_rd && cap_valid |=> host_rdata[10:9] == strap_size_limit) else $error("size field wrong");
  a_cap_opt: assert property (
    cap_rd && cap_valid |=> {host_rdata[30:28], host_rdata[8:5], host_rdata[3], host_rdata[1]}
      == {strap_revision, strap_burst_fixed, strap_cmd_ready_irq, strap_falling_edge,
      strap_rising_edge, strap_high_level, strap_status_valid_irq}) else $error("strap bits wrong");
  a_cap_invalid: assert property (
    cap_rd && !cap_valid |=> host_rdata == 32'h0) else $error("invalid kind read not zero");
  a_valid_lag: assert property (
    $past(rst_n) |-> cap_valid == ($past(interface_kind) == FIC_KIND_FIFO_A
      || $past(interface_kind) == FIC_KIND_FIFO_B)) else $error("cap_valid wrong");
  a_wide_abort: assert property (
    take && host_addr == FIC_OFS_WIDE_FIFO && strap_size_limit == FIC_SIZE_LEGACY |=> host_abort)
    else $error("wide port not aborted");
  a_len_abort: assert property (
    take && host_addr == FIC_OFS_BYTE_FIFO && (host_len == 7'h0 || (host_len > max_len
      && !strap_lpc_mode)) |=> host_abort) else $error("bad length not aborted");
  a_small_ok: assert property (
    take && host_addr == FIC_OFS_WIDE_FIFO && strap_size_limit != FIC_SIZE_LEGACY
      && host_len inside {[1:4]} |=> !host_abort) else $error("short wide transfer aborted");
  a_cap_write: assert property (
    take && host_we && host_addr == FIC_OFS_CAP |=> host_ack && !host_abort)
    else $error("capability write not acked");
  a_wr_hold: assert property (
    fifo_wr_valid && !fifo_wr_ready |=> fifo_wr_valid && $stable(fifo_wr_data))
    else $error("stalled byte dropped");
  a_wait_cause: assert property (
    host_wait |-> ($past(fifo_wr_valid) && !$past(fifo_wr_ready)) || !$past(fifo_rd_valid))
    else $error("wait without a stall");
  a_wait_stall: assert property (
    fifo_wr_valid && !fifo_wr_ready && host_wvalid && !host_byte_ack |=> host_wait)
    else $error("full fifo not stalled");
endmodule
bind fic_top fic_top_asserts u_chk (.sys_clk, .rst_n, .host_req, .host_we, .host_addr,
  .host_len, .host_ack, .host_abort, .host_rdata, .interface_kind, .strap_revision,
  .strap_size_limit, .strap_burst_fixed, .strap_cmd_ready_irq, .strap_falling_edge,
  .strap_rising_edge, .strap_high_level, .strap_status_valid_irq, .strap_lpc_mode,
  .fifo_wr_valid, .fifo_wr_data, .fifo_wr_ready, .cap_valid, .fifo_rd_valid, .host_wait,
  .host_byte_ack, .host_wvalid);
`default_nettype wire

//--- verif/fic_top_tb.sv
// Testbench: capability word, port acceptance and aborts over four strap settings
`timescale 1ns/10ps
`default_nettype none
module fic_top_tb;
  import fic_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_req, host_we, host_wvalid, host_ack, host_abort, host_wait, host_byte_ack;
  logic [15:0] host_addr;
  logic [6:0]  host_len;
  logic [7:0]  host_wdata, fifo_wr_data;
  logic [31:0] host_rdata, cw;
  logic [3:0]  interface_kind = 4'h0;
  logic [12:0] sp = 13'h0;
  logic [1:0]  sz = 2'h0;
  logic        lpc = 1'b0;
  logic        fifo_wr_valid, fifo_rd_take, cap_valid, wide_port_enabled;
  logic        fifo_wr_ready = 1'b0;
  logic        fifo_rd_valid = 1'b1;
  logic [7:0]  fifo_rd_data = 8'h0;
  logic [64:0] notes[$];
  int          err_count = 0;
  int          samples_checked = 0;
  int          pushes = 0;
  int          takes = 0;
  always #5 sys_clk = ~sys_clk;
  // Handshakes counted with the values the design saw at this edge
  always @(posedge sys_clk) begin
    if (fifo_wr_valid === 1'b1 && fifo_wr_ready === 1'b1) pushes++;
    if (fifo_rd_take === 1'b1) takes++;
  end
  // Random stalls on the command FIFO side
  always @(negedge sys_clk) fifo_wr_ready <= 1'($urandom_range(1));
  fic_top uut (.sys_clk, .rst_n, .host_req, .host_we, .host_addr, .host_len, .host_wvalid,
    .host_wdata, .host_ack, .host_abort, .host_wait, .host_byte_ack, .host_rdata,
    .interface_kind, .strap_top_bit(sp[12]), .strap_revision(sp[11:9]), .strap_size_limit(sz),
    .strap_burst_fixed(sp[7]), .strap_cmd_ready_irq(sp[6]), .strap_falling_edge(sp[5]),
    .strap_rising_edge(sp[4]), .strap_high_level(sp[3]), .strap_status_valid_irq(sp[2]),
    .strap_lpc_mode(lpc), .fifo_wr_valid, .fifo_wr_data, .fifo_wr_ready, .fifo_rd_valid,
    .fifo_rd_data, .fifo_rd_take, .cap_valid, .wide_port_enabled);
  fic_host_model hm (.sys_clk, .host_ack, .host_abort, .host_byte_ack, .host_req, .host_we,
    .host_addr, .host_len, .host_wvalid, .host_wdata);
  function automatic logic [6:0] mx(input logic [1:0] v);
    return v == 2'h3 ? 7'h40 : v == 2'h2 ? 7'h20 : v == 2'h1 ? 7'h08 : 7'h01;
  endfunction
  task automatic op(input logic w, input logic [15:0] a, input logic [6:0] n, input logic ab,
                    input logic [31:0] m, input logic [31:0] d);
    int   p;
    int   q;
    int   ep;
    int   eq;
    logic fifo;
    p = pushes;
    q = takes;
    fifo = !ab && (a == FIC_OFS_BYTE_FIFO || a == FIC_OFS_WIDE_FIFO);
    ep = (fifo && w) ? int'(n) : 0;
    eq = (fifo && !w) ? int'(n) : 0;
    notes.push_back({ab, m, d & m});
    hm.xfer(w, a, n);
    samples_checked++;
    if (pushes - p != ep || takes - q != eq) begin
      err_count++;
      $display("BAD %0t fifo moved %0d pushes %0d takes", $time, pushes - p, takes - q);
    end
  endtask
  task stop_test;
    if (notes.size() != 0) begin
      err_count++;
      $display("BAD %0t %0d answers never came", $time, notes.size());
    end
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    if (host_ack === 1'b1 || host_abort === 1'b1) begin
      samples_checked++;
      if (notes.size() == 0) begin
        err_count++;
        $display("BAD %0t unexpected answer", $time);
      end else begin
        if (host_abort !== notes[0][64] || host_ack === notes[0][64] ||
            (host_rdata & notes[0][63:32]) !== notes[0][31:0]) begin
          err_count++;
          $display("BAD %0t answer %h abort %b expected %h", $time, host_rdata, host_abort,
                   notes[0][31:0]);
        end
        void'(notes.pop_front());
      end
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'heb59));
    for (int s = 0; s < 4; s++) begin
      rst_n = 1'b0;
      sz = 2'(s);
      lpc = (s == 2);
      interface_kind = (s == 2) ? 4'h5 : {4{s[0]}};
      sp = 13'($urandom);
      fifo_rd_data = 8'($urandom);
      repeat (s == 0 ? 12 : 3) @(negedge sys_clk);
      rst_n = 1'b1;
      // Straps are captured a few edges after release
      repeat (5) @(negedge sys_clk);
      samples_checked++;
      if (wide_port_enabled !== (sz != 2'h0) || cap_valid !== (s != 2)) begin
        err_count++;
        $display("BAD %0t status wide %b valid %b", $time, wide_port_enabled, cap_valid);
      end
      cw = (s == 2) ? 32'h0 : {sp[12], sp[11:9], 17'h0, sz, sp[7:4], 1'b1, sp[3], 1'b1,
                               sp[2], 1'b1};
      op(1'b0, FIC_OFS_CAP, 7'h1, 1'b0, '1, cw);
      op(1'b1, FIC_OFS_CAP, 7'h4, 1'b0, 32'h0, 32'h0);
      op(1'b0, FIC_OFS_CAP, 7'h1, 1'b0, '1, cw);
      op(1'b1, FIC_OFS_WIDE_FIFO, 7'h4, s == 0, 32'h0, 32'h0);
      op(1'b0, FIC_OFS_WIDE_FIFO, 7'h2, s == 0, {24'h0, {8{s != 0}}}, {24'h0, fifo_rd_data});
      op(1'b1, FIC_OFS_BYTE_FIFO, mx(sz), 1'b0, 32'h0, 32'h0);
      op(1'b1, FIC_OFS_BYTE_FIFO, mx(sz) + 7'h1, !lpc, 32'h0, 32'h0);
      op(1'b0, FIC_OFS_BYTE_FIFO, 7'h1, 1'b0, 32'hff, {24'h0, fifo_rd_data});
      op(1'b1, FIC_OFS_BYTE_FIFO, 7'h0, 1'b1, 32'h0, 32'h0);
      op(1'b0, 16'h0080, 7'h1, 1'b0, '1, 32'h0);
      $display("test %0d done", s);
    end
    repeat (2) @(negedge sys_clk);
    stop_test();
  end
endmodule
`default_nettype wire
